// File: tefs_pkg.sv
/*
  Constants and carrier types for the timer
  event status flag block.
  Assumes one 100 MHz clock and a 32-bit
  AHB-Lite register bus.
*/
package tefs_pkg;

  // ------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVGEN = 8'h14;

  // ------------------------------------------
  // Field positions of the status register
  // ------------------------------------------
  localparam int NUM_CH = 4;
  localparam int BIT_UPD = 0;
  localparam int BIT_MC0 = 1;
  localparam int BIT_TRIG = 6;
  localparam int BIT_OC0 = 9;

  // Implemented bits; all others read zero
  localparam logic [15:0] STATUS_MASK = 16'h1E5F;
  localparam logic [15:0] EN_MASK = 16'h005F;

  // ------------------------------------------
  // Control register fields
  // ------------------------------------------
  localparam int CTRL_UPDATE_DISABLE = 0;
  localparam int CTRL_URS = 1;
  localparam int CTRL_GATED = 2;
  localparam int CTRL_TRIG_FALL = 3;
  localparam int CTRL_CENTER = 4;
  localparam int CTRL_INMODE0 = 8;
  localparam logic [15:0] CTRL_MASK = 16'h0F1F;

  // ------------------------------------------
  // Event generation register fields
  // ------------------------------------------
  localparam int EVGEN_UG = 0;
  localparam int EVGEN_TG = 6;

  // ------------------------------------------
  // Reset values
  // ------------------------------------------
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // Strobes from the counter core, one cycle each
  typedef struct packed {
    logic rep_wrap;
    logic sw_reinit;
    logic trig_reinit;
    logic [3:0] match;
    logic [3:0] capture;
    logic [3:0] capture_read;
  } tefs_core_ev_t;

endpackage : tefs_pkg

// File: tefs_top.sv
/*
  Status flag logic of a general-purpose timer:
  update, trigger, match/capture and repeat
  capture flags, enables for all but the repeat capture flags, one interrupt.
  Assumes the counter core runs on ref_clk and
  hands its events over as one-cycle strobes;
  trigger_input is an asynchronous pin.
*/
`timescale 1ns/100ps
module tefs_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Event strobes from the counter core
  input wire tefs_pkg::tefs_core_ev_t core_ev,
  // Trigger pin
  input wire logic trigger_input,
  // Interrupt and event outputs
  output logic irq,
  output logic update_event,
  output logic trigger_event
);

  // ------------------------------------------
  // State
  // ------------------------------------------
  logic [15:0] ctrl; // Mode and source control
  logic [15:0] irq_en; // Interrupt enables
  logic [15:0] timer_event_flags; // Status
  logic dp_valid; // Data phase pending
  logic dp_write; // Pending access is a write
  logic [7:0] dp_addr; // Pending byte address
  logic trig_s1; // Synchroniser stage one
  logic trig_s2; // Synchroniser stage two
  logic trig_s3; // Edge detect history

  // ------------------------------------------
  // Bus decode
  // ------------------------------------------
  // Only the low address byte is decoded, so
  // the map repeats through the slave window.
  wire addr_take = hsel & htrans[1] & hready;
  wire wr_phase = dp_valid & dp_write;
  wire wr_ctrl = wr_phase & (dp_addr == tefs_pkg::OFS_CTRL);
  wire wr_en = wr_phase & (dp_addr == tefs_pkg::OFS_IRQ_EN);
  wire wr_status = wr_phase & (dp_addr == tefs_pkg::OFS_STATUS);
  wire wr_evgen = wr_phase & (dp_addr == tefs_pkg::OFS_EVGEN);
  // Read mux; unmapped words read zero
  wire [15:0] rd_sel =
    (haddr[7:0] == tefs_pkg::OFS_CTRL) ? ctrl :
    (haddr[7:0] == tefs_pkg::OFS_IRQ_EN) ? irq_en :
    (haddr[7:0] == tefs_pkg::OFS_STATUS) ? timer_event_flags :
    16'h0000;
  wire rd_take = addr_take & ~hwrite;
  wire [31:0] next_rdata = rd_take ? {16'h0000, rd_sel} : tefs_pkg::RST_RDATA;

  // ------------------------------------------
  // Control fields
  // ------------------------------------------
  wire update_disable = ctrl[tefs_pkg::CTRL_UPDATE_DISABLE];
  wire update_request_source = ctrl[tefs_pkg::CTRL_URS];
  wire gated_mode = ctrl[tefs_pkg::CTRL_GATED];
  wire trig_fall = ctrl[tefs_pkg::CTRL_TRIG_FALL];
  wire center_aligned = ctrl[tefs_pkg::CTRL_CENTER];
  wire [3:0] in_mode = ctrl[tefs_pkg::CTRL_INMODE0 +: 4];

  // ------------------------------------------
  // Trigger edges and event sources
  // ------------------------------------------
  wire trig_rise = trig_s2 & ~trig_s3;
  wire trig_falls = ~trig_s2 & trig_s3;
  wire trig_valid = trig_fall ? trig_falls : trig_rise;
  wire trig_any = trig_rise | trig_falls;
  // Software strobes take effect in data phase
  wire update_generate = wr_evgen & hwdata[tefs_pkg::EVGEN_UG];
  wire trig_generate = wr_evgen & hwdata[tefs_pkg::EVGEN_TG];
  // Gated mode counts both edges
  wire trig_ev = (gated_mode ? trig_any : trig_valid) | trig_generate;
  // Software sources are masked by the
  // request-source bit; wraps are not.
  wire sw_src = update_generate | core_ev.sw_reinit;
  wire open_src = ~update_request_source & (sw_src | core_ev.trig_reinit);
  wire upd_ev = ~update_disable & (core_ev.rep_wrap | open_src);

  // ------------------------------------------
  // Flag set and clear vectors
  // ------------------------------------------
  logic [15:0] set_vec; // Hardware sets
  logic [15:0] clr_vec; // Software or read clears
  logic [15:0] next_status; // Next flag state
  logic [3:0] mc_set; // Match/capture sets
  logic [3:0] mc_clr; // Match/capture clears
  logic [3:0] oc_set; // Repeat-capture sets
  logic [3:0] oc_clr; // Repeat-capture clears

  // Per-channel flag conditions
  genvar ch;
  generate
    for (ch = 0; ch < tefs_pkg::NUM_CH; ch++) begin : g_ch
      // Output mode: match, but not in centre mode
      assign mc_set[ch] = in_mode[ch] ? core_ev.capture[ch] :
        (core_ev.match[ch] & ~center_aligned);
      // Write of zero, or capture register read
      assign mc_clr[ch] = (wr_status & ~hwdata[tefs_pkg::BIT_MC0 + ch]) |
        (in_mode[ch] & core_ev.capture_read[ch]);
      // Capture on a flag still set
      assign oc_set[ch] = in_mode[ch] & core_ev.capture[ch] &
        timer_event_flags[tefs_pkg::BIT_MC0 + ch];
      // Only a written zero clears it
      assign oc_clr[ch] = wr_status & ~hwdata[tefs_pkg::BIT_OC0 + ch];
    end
  endgenerate

  // Collect sets and clears into register layout
  always_comb begin
    set_vec = 16'h0000;
    clr_vec = 16'h0000;
    set_vec[tefs_pkg::BIT_UPD] = upd_ev;
    clr_vec[tefs_pkg::BIT_UPD] = wr_status & ~hwdata[tefs_pkg::BIT_UPD];
    set_vec[tefs_pkg::BIT_TRIG] = trig_ev;
    clr_vec[tefs_pkg::BIT_TRIG] = wr_status & ~hwdata[tefs_pkg::BIT_TRIG];
    set_vec[tefs_pkg::BIT_MC0 +: 4] = mc_set;
    clr_vec[tefs_pkg::BIT_MC0 +: 4] = mc_clr;
    set_vec[tefs_pkg::BIT_OC0 +: 4] = oc_set;
    clr_vec[tefs_pkg::BIT_OC0 +: 4] = oc_clr;
  end

  // Set wins over clear; reserved bits stay zero
  assign next_status = (set_vec | (timer_event_flags & ~clr_vec)) &
    tefs_pkg::STATUS_MASK;

  // ------------------------------------------
  // Registers
  // ------------------------------------------
  // Bus address phase capture
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_valid <= addr_take;
      dp_write <= hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  // Bus answer; always zero wait, always OKAY
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata <= tefs_pkg::RST_RDATA;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= next_rdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Control and enable registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl <= tefs_pkg::RST_REG;
      irq_en <= tefs_pkg::RST_REG;
    end else begin
      if (wr_ctrl) begin
        ctrl <= hwdata[15:0] & tefs_pkg::CTRL_MASK;
      end
      if (wr_en) begin
        irq_en <= hwdata[15:0] & tefs_pkg::EN_MASK;
      end
    end
  end

  // Trigger pin synchroniser and history
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else begin
      trig_s1 <= trigger_input;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // Flags, interrupt and event pulses
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timer_event_flags <= tefs_pkg::RST_REG;
      irq <= 1'b0;
      update_event <= 1'b0;
      trigger_event <= 1'b0;
    end else begin
      timer_event_flags <= next_status;
      // One cycle behind the flags it reflects
      irq <= |(timer_event_flags & irq_en);
      update_event <= upd_ev;
      trigger_event <= trig_ev;
    end
  end

  // ------------------------------------------
  // Assertions
  // ------------------------------------------
  property p_oc1_set;
    @(posedge ref_clk) disable iff (reset)
    (in_mode[0] && core_ev.capture[0] && timer_event_flags[1]) |=>
      timer_event_flags[9];
  endproperty
  a_oc1_set: assert property (p_oc1_set)
    else $error("ch1 repeat capture not flagged");

  property p_oc1_hold;
    @(posedge ref_clk) disable iff (reset)
    $fell(timer_event_flags[9]) |->
      $past(wr_status) && !$past(hwdata[9]);
  endproperty
  a_oc1_hold: assert property (p_oc1_hold)
    else $error("ch1 repeat flag fell without zero write");

  property p_oc4_set;
    @(posedge ref_clk) disable iff (reset)
    (in_mode[3] && core_ev.capture[3] && timer_event_flags[4]) |=>
      timer_event_flags[12];
  endproperty
  a_oc4_set: assert property (p_oc4_set)
    else $error("ch4 repeat capture not flagged");

  property p_trig_flag;
    @(posedge ref_clk) disable iff (reset)
    trig_ev |=> timer_event_flags[6] && trigger_event;
  endproperty
  a_trig_flag: assert property (p_trig_flag)
    else $error("trigger flag not set");

  property p_gated_edge;
    @(posedge ref_clk) disable iff (reset)
    (gated_mode && $changed(trig_s2)) |-> ##1 trigger_event;
  endproperty
  a_gated_edge: assert property (p_gated_edge)
    else $error("gated edge missed");

  property p_match_out;
    @(posedge ref_clk) disable iff (reset)
    (!in_mode[0] && core_ev.match[0] && !center_aligned) |=>
      timer_event_flags[1];
  endproperty
  a_match_out: assert property (p_match_out)
    else $error("ch1 match not flagged");

  property p_center_quiet;
    @(posedge ref_clk) disable iff (reset)
    (!in_mode[0] && center_aligned && !timer_event_flags[1]) |=>
      !timer_event_flags[1];
  endproperty
  a_center_quiet: assert property (p_center_quiet)
    else $error("ch1 flag set in centre mode");

  property p_read_clear;
    @(posedge ref_clk) disable iff (reset)
    (in_mode[1] && core_ev.capture_read[1] && !core_ev.capture[1]) |=>
      !timer_event_flags[2];
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("ch2 flag not cleared by read");

  property p_wrap_upd;
    @(posedge ref_clk) disable iff (reset)
    (core_ev.rep_wrap && !update_disable) |=>
      timer_event_flags[0] && update_event;
  endproperty
  a_wrap_upd: assert property (p_wrap_upd)
    else $error("wrap gave no update");

  property p_ug_upd;
    @(posedge ref_clk) disable iff (reset)
    (update_generate && !update_request_source && !update_disable) |=>
      timer_event_flags[0];
  endproperty
  a_ug_upd: assert property (p_ug_upd)
    else $error("update generate gave no flag");

  property p_trig_reinit;
    @(posedge ref_clk) disable iff (reset)
    (core_ev.trig_reinit && update_request_source && !core_ev.rep_wrap) |=>
      !update_event;
  endproperty
  a_trig_reinit: assert property (p_trig_reinit)
    else $error("masked reinit gave update");

  property p_irq;
    @(posedge ref_clk) disable iff (reset)
    if ((timer_event_flags & irq_en) != 16'h0000) ##1 irq else ##1 !irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq does not follow enabled flags");

  property p_reserved;
    @(posedge ref_clk) disable iff (reset)
    (timer_event_flags & ~tefs_pkg::STATUS_MASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bit set");

  property p_set_wins;
    @(posedge ref_clk) disable iff (reset)
    (upd_ev && wr_status && !hwdata[0]) |=> timer_event_flags[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat set");

endmodule : tefs_top

// File: testbench.sv
/*
  Self-checking bench for tefs_top: AHB-Lite tasks
  and one task per scenario.
  Assumes a zero-wait slave whose hreadyout is hready.
*/
`timescale 1ns/100ps
// Count and report one comparison
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t got %0h expected %0h", $time, (a), (b)); end end
module testbench;
  // ------------------------------------------
  // Signals
  // ------------------------------------------
  logic ref_clk, reset, hsel, hwrite, trigger_input;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, irq, update_event, trigger_event;
  tefs_pkg::tefs_core_ev_t core_ev, e;
  int mismatches, tests_run, trg_cnt;
  localparam logic [7:0] ST = tefs_pkg::OFS_STATUS;

  tefs_top dut (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .core_ev(core_ev), .trigger_input(trigger_input), .irq(irq),
    .update_event(update_event), .trigger_event(trigger_event));

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Trigger pulse counter
  always @(posedge ref_clk) if (trigger_event === 1'b1) trg_cnt++;

  // ------------------------------------------
  // Bus and event tasks
  // ------------------------------------------
  // Bounded wait for hready; a hang counts as a mismatch
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
  endtask : wait_rdy

  // Single write; x is driven on core_ev during the data phase
  task wr(input logic [7:0] a, input logic [31:0] d, input tefs_pkg::tefs_core_ev_t x);
    @(posedge ref_clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= 1'b1; haddr <= {24'h000000, a};
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; core_ev <= x;
    wait_rdy();
    core_ev <= '0;
  endtask : wr

  // Single read compared against exp
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= 1'b0; haddr <= {24'h000000, a};
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0;
    wait_rdy();
    `CHK(hrdata, exp)
    `CHK(hresp, 1'b0)
  endtask : rd

  // One-cycle strobe on core_ev
  task pulse(input tefs_pkg::tefs_core_ev_t x);
    @(posedge ref_clk);
    core_ev <= x;
    @(posedge ref_clk);
    core_ev <= '0;
  endtask : pulse

  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  // Reset values, masks, unmapped offset
  task t_regs;
    rd(tefs_pkg::OFS_CTRL, 32'h0);
    rd(tefs_pkg::OFS_IRQ_EN, 32'h0);
    rd(ST, 32'h0);
    rd(tefs_pkg::OFS_EVGEN, 32'h0);
    rd(8'h04, 32'h0);
    wr(tefs_pkg::OFS_CTRL, 32'hFFFFFFFF, '0);
    rd(tefs_pkg::OFS_CTRL, {16'h0000, tefs_pkg::CTRL_MASK});
    wr(tefs_pkg::OFS_IRQ_EN, 32'hFFFFFFFF, '0);
    rd(tefs_pkg::OFS_IRQ_EN, {16'h0000, tefs_pkg::EN_MASK});
    wr(tefs_pkg::OFS_CTRL, 32'h0, '0);
    wr(tefs_pkg::OFS_IRQ_EN, 32'h0, '0);
  endtask : t_regs

  // One update source k under control word c
  task upd(input logic [31:0] c, input int k, input logic [31:0] exp);
    wr(tefs_pkg::OFS_CTRL, c, '0);
    e = '0;
    if (k == 3) wr(tefs_pkg::OFS_EVGEN, 32'h1, '0);
    else begin
      e.rep_wrap = (k == 0); e.sw_reinit = (k == 1); e.trig_reinit = (k == 2);
      pulse(e);
    end
    rd(ST, exp);
    wr(ST, 32'hFFFE, '0);
  endtask : upd

  // Update flag, pulse, irq, write-zero clear, set beats clear
  task t_update;
    e = '0; e.rep_wrap = 1'b1;
    pulse(e);
    #1 `CHK(update_event, 1'b1)
    rd(ST, 32'h1);
    `CHK(irq, 1'b0)
    wr(tefs_pkg::OFS_IRQ_EN, 32'h1, '0);
    repeat (2) @(posedge ref_clk);
    #1 `CHK(irq, 1'b1)
    wr(ST, 32'hFFFF, '0);
    rd(ST, 32'h1);
    wr(ST, 32'hFFFE, e);
    rd(ST, 32'h1);
    wr(ST, 32'hFFFE, '0);
    rd(ST, 32'h0);
    `CHK(irq, 1'b0)
    upd(32'h0, 0, 32'h1);
    upd(32'h0, 1, 32'h1);
    upd(32'h0, 3, 32'h1);
    upd(32'h0, 2, 32'h1);
    upd(32'h2, 1, 32'h0);
    upd(32'h2, 3, 32'h0);
    upd(32'h2, 2, 32'h0);
    upd(32'h2, 0, 32'h1);
    upd(32'h1, 0, 32'h0);
    upd(32'h1, 1, 32'h0);
    wr(tefs_pkg::OFS_CTRL, 32'h0, '0);
    wr(tefs_pkg::OFS_IRQ_EN, 32'h0, '0);
  endtask : t_update

  // Pin moves to lvl under control c; sync needs a few cycles
  task trg(input logic [31:0] c, input logic lvl, input logic [31:0] exp);
    wr(tefs_pkg::OFS_CTRL, c, '0);
    trigger_input <= lvl;
    repeat (6) @(posedge ref_clk);
    rd(ST, exp);
    wr(ST, 32'hFFBF, '0);
  endtask : trg

  // Edge selection, gated mode, software trigger
  task t_trigger;
    trg(32'h0, 1'b1, 32'h40);
    trg(32'h0, 1'b0, 32'h0);
    trg(32'h8, 1'b1, 32'h0);
    trg(32'h8, 1'b0, 32'h40);
    trg(32'h4, 1'b1, 32'h40);
    trg(32'h4, 1'b0, 32'h40);
    `CHK(trg_cnt, 4)
    wr(tefs_pkg::OFS_IRQ_EN, 32'h40, '0);
    wr(tefs_pkg::OFS_EVGEN, 32'h40, '0);
    rd(ST, 32'h40);
    `CHK(irq, 1'b1)
    wr(ST, 32'hFFBF, '0);
    wr(tefs_pkg::OFS_IRQ_EN, 32'h0, '0);
    wr(tefs_pkg::OFS_CTRL, 32'h0, '0);
  endtask : t_trigger

  // Match, centre block, capture, repeat capture, read clear
  task t_chan;
    for (int n = 0; n < 4; n++) begin
      e = '0; e.match[n] = 1'b1;
      pulse(e);
      e = '0; e.capture_read[n] = 1'b1;
      pulse(e);
      rd(ST, 32'h1 << (n + 1));
      wr(ST, ~(32'h1 << (n + 1)), '0);
    end
    wr(tefs_pkg::OFS_CTRL, 32'h10, '0);
    e = '0; e.match = 4'hF;
    pulse(e);
    rd(ST, 32'h0);
    wr(tefs_pkg::OFS_CTRL, 32'h0F00, '0);
    for (int n = 0; n < 4; n++) begin
      wr(tefs_pkg::OFS_IRQ_EN, 32'h1 << (n + 1), '0);
      e = '0; e.capture[n] = 1'b1;
      pulse(e);
      rd(ST, 32'h1 << (n + 1));
      `CHK(irq, 1'b1)
      pulse(e);
      rd(ST, (32'h1 << (n + 1)) | (32'h1 << (n + 9)));
      e = '0; e.capture_read[n] = 1'b1;
      pulse(e);
      rd(ST, 32'h1 << (n + 9));
      `CHK(irq, 1'b0)
      wr(ST, ~(32'h1 << (n + 9)), '0);
      rd(ST, 32'h0);
    end
    wr(tefs_pkg::OFS_CTRL, 32'h0, '0);
  endtask : t_chan

  // ------------------------------------------
  // Verdict and run control
  // ------------------------------------------
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Watchdog well beyond the few hundred cycles needed
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end

  // Main sequence
  initial begin
    reset = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; core_ev = '0; trigger_input = 1'b0;
    mismatches = 0; tests_run = 0; trg_cnt = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_update();
    t_trigger();
    t_chan();
    finish_test();
  end
endmodule : testbench
